// ---- design/tox_pkg.sv ----
/*
  Shared constants for the transmit overhead insert and error inject block.
  Assumes an 8-bit parallel register port and a per-bit transmit stream.
*/
`default_nettype none

package tox_pkg;
  // Register addresses on the parallel port
  localparam logic [7:0] ADDR_FRAME_FORMAT = 8'h72;
  localparam logic [7:0] ADDR_ERROR_INSERT = 8'h73;
  localparam logic [7:0] ADDR_MANUAL = 8'h74;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Bits 7 and 6 of the frame format are reserved and read zero
  localparam logic [7:0] FMT_MASK = 8'h3F;
  // Direction bit is a stored level, all others are one-shot requests
  localparam logic [7:0] ERR_PEND_MASK = 8'hEF;

  // Frame format fields
  localparam int FMT_MYEL = 5;
  localparam int FMT_YEL = 4;
  localparam int FMT_MF = 3;
  localparam int FMT_FE = 2;
  localparam int FMT_CRC = 1;
  localparam int FMT_FBIT = 0;

  // Error insert fields
  localparam int ERR_MAS = 7;
  localparam int ERR_MF = 6;
  localparam int ERR_PAT = 5;
  localparam int ERR_DIR = 4;
  localparam int ERR_SHIFT = 3;
  localparam int ERR_CRC = 2;
  localparam int ERR_FBIT = 1;
  localparam int ERR_LCV = 0;

  // Manual spare and far-end block error fields
  localparam int MAN_SPARE_LO = 3;
  localparam int MAN_FEBE15 = 2;
  localparam int MAN_FEBE13 = 1;
  localparam int MAN_OVR = 0;
  localparam int SPARE_BYTES = 5;

  // Consecutive marks needed before a violation may be placed
  localparam logic [1:0] MARK_RUN_NEEDED = 2'h2;

  typedef enum logic {ENC_IDLE, ENC_SECOND} tox_enc_e;
endpackage

`default_nettype wire

// ---- design/tox_line_if.sv ----
/*
  Carrier between the overhead formatter and the bipolar line encoder.
  Assumes both ends sit on the same core clock.
*/
`timescale 1ns/10ps
`default_nettype none

interface tox_line_if;
  logic bit_val;
  logic bit_vld;
  logic lcv_req;
  logic e1_mode;
  logic lcv_done;
  logic pos;
  logic neg;

  modport fmt (output bit_val, output bit_vld, output lcv_req, output e1_mode,
               input lcv_done, input pos, input neg);
  modport enc (input bit_val, input bit_vld, input lcv_req, input e1_mode,
               output lcv_done, output pos, output neg);
endinterface

`default_nettype wire

// ---- design/tox_line_encoder.sv ----
/*
  Bipolar mark encoder with line code violation injection.
  Assumes one valid strobe per line bit from the formatter, same clock.
*/
`timescale 1ns/10ps
`default_nettype none

module tox_line_encoder (
  input wire logic i_clk,
  input wire logic i_reset,
  tox_line_if.enc lif
);
  typedef struct packed {
    tox_pkg::tox_enc_e state;
    logic pol;
    logic [1:0] run;
    logic done;
    logic pos;
    logic neg;
  } tox_enc_s;

  tox_enc_s st_q;
  tox_enc_s st_d;
  logic viol;
  logic start_ok;

  // A violation waits for two marks so no framing or CRC bit is hurt
  assign start_ok = lif.lcv_req & ~st_q.done & (st_q.run == tox_pkg::MARK_RUN_NEEDED);

  // Next state of the encoder
  always_comb
  begin
    st_d = st_q;
    viol = 1'b0;
    st_d.done = 1'b0;
    st_d.pos = 1'b0;
    st_d.neg = 1'b0;
    if (lif.bit_vld & ~lif.bit_val)
    begin
      st_d.run = 2'h0;
    end
    else if (lif.bit_vld)
    begin
      case (st_q.state)
        tox_pkg::ENC_IDLE:
        begin
          if (start_ok)
          begin
            viol = 1'b1;
            if (lif.e1_mode)
              st_d.state = tox_pkg::ENC_SECOND;
            else
              st_d.done = 1'b1;
          end
        end
        tox_pkg::ENC_SECOND:
        begin
          viol = 1'b1;
          st_d.done = 1'b1;
          st_d.state = tox_pkg::ENC_IDLE;
        end
        default:
        begin
          st_d.state = tox_pkg::ENC_IDLE;
        end
      endcase
      st_d.pol = viol ? st_q.pol : ~st_q.pol;
      st_d.pos = st_d.pol;
      st_d.neg = ~st_d.pol;
      if (viol)
        st_d.run = 2'h0;
      else if (st_q.run != tox_pkg::MARK_RUN_NEEDED)
        st_d.run = st_q.run + 2'h1;
    end
  end

  // State register
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      st_q <= '{state: tox_pkg::ENC_IDLE, pol: 1'b0, run: 2'h0, done: 1'b0,
                pos: 1'b0, neg: 1'b0};
    else
      st_q <= st_d;
  end

  assign lif.lcv_done = st_q.done;
  assign lif.pos = st_q.pos;
  assign lif.neg = st_q.neg;

  // Checks on the violation injector
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  chk_t1_single_viol: assert property (
    (lif.bit_vld & lif.bit_val & start_ok & ~lif.e1_mode & st_q.state == tox_pkg::ENC_IDLE)
    |=> lif.lcv_done && (st_q.pol == $past(st_q.pol)) && (st_q.pos | st_q.neg))
    else $error("T1 violation not a same polarity mark");
  chk_ami_alternate: assert property (
    (lif.bit_vld & lif.bit_val & ~lif.lcv_req & st_q.state == tox_pkg::ENC_IDLE)
    |=> st_q.pol != $past(st_q.pol))
    else $error("Marks did not alternate");
  cov_e1_double: cover property (st_q.state == tox_pkg::ENC_SECOND ##[1:50] lif.lcv_done);
endmodule

`default_nettype wire

// ---- design/tox_overhead.sv ----
/*
  Transmit overhead insertion and forced error injection, top module.
  Assumes a bit strobe with position flags from the frame timing logic,
  generated overhead values from the formatters, and slip buffer data.
*/
// What this block does
// - Multiframe yellow inserted only in E1 modes
// - Yellow enable selects formatter yellow alarm bits
// - Alignment enable inserts multiframe pattern, else passthrough
// - Automatic far-end error drives frame 13/15 low
// - CRC enable inserts computed check bits
// - Framing enable inserts terminal or FAS pattern
// - Write one injects exactly one error each
// - Inverts first signalling multiframe alignment bit
// - Inverts next multiframe alignment bit
// - Inverts next pseudo-random pattern bit
// - Alignment shift drops or inserts one bit
// - Shift adjusts slip buffer read rate
// - Inverts next CRC or framing bit
// - T1 violation waits for two marks
// - E1 violation sends two same-polarity violations
// - Spare-byte enables pick manual spare data
// - Far-end bits: passthrough, automatic or manual
// - Received CRC errors held one multiframe
// - Disabled overhead passes system data unchanged
`timescale 1ns/10ps
`default_nettype none

module tox_overhead #(
  parameter int SPARE_BYTES = tox_pkg::SPARE_BYTES
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RESET,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic [7:0] I_REG_WDATA,
  input wire logic I_REG_WR,
  output logic [7:0] O_REG_RDATA,
  input wire logic I_LINE_RATE_T1,
  input wire logic I_BIT_EN,
  input wire logic I_SYS_DATA,
  input wire logic I_POS_FBIT,
  input wire logic I_POS_MF,
  input wire logic I_POS_CRC,
  input wire logic I_POS_YEL,
  input wire logic I_POS_MYEL,
  input wire logic I_POS_MAS_FIRST,
  input wire logic I_POS_TS0_BIT1,
  input wire logic I_POS_FAS_FIRST,
  input wire logic I_POS_FEBE13,
  input wire logic I_POS_FEBE15,
  input wire logic [SPARE_BYTES-1:0] I_POS_SPARE,
  input wire logic I_MF_START,
  input wire logic I_GEN_FBIT,
  input wire logic I_GEN_MF,
  input wire logic I_GEN_CRC,
  input wire logic I_GEN_YEL,
  input wire logic I_GEN_MYEL,
  input wire logic I_GEN_SPARE,
  input wire logic I_PRBS_ACTIVE,
  input wire logic I_PRBS_BIT,
  input wire logic I_RX_CRC_ERR_SMF1,
  input wire logic I_RX_CRC_ERR_SMF2,
  output logic O_TX_DATA,
  output logic O_TX_VALID,
  output logic O_STALL,
  output logic O_SLIP_ADJ,
  output logic O_SLIP_ADJ_INSERT,
  output logic O_DIG_POS,
  output logic O_DIG_NEG,
  output logic O_ANA_POS,
  output logic O_ANA_NEG
);
  typedef struct packed {
    logic [7:0] fmt;
    logic [7:0] err;
    logic [7:0] man;
    logic [7:0] rdata;
    logic tx_data;
    logic tx_valid;
    logic slip_adj;
    logic slip_ins;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] last;
    logic [1:0] hold;
    logic [1:0] use_err;
  } tox_ovh_s;

  tox_ovh_s st_q;
  tox_ovh_s st_d;
  tox_line_if lif ();

  logic e1;
  logic wr_fmt;
  logic wr_err;
  logic wr_man;
  logic [1:0] crc_evt;
  logic shift_drop;
  logic shift_ins;
  logic [SPARE_BYTES-1:0] spare_hit;
  logic [7:0] clr;
  logic [7:0] set;
  logic b;

  assign e1 = ~I_LINE_RATE_T1;
  assign wr_fmt = I_REG_WR & (I_REG_ADDR == tox_pkg::ADDR_FRAME_FORMAT);
  assign wr_err = I_REG_WR & (I_REG_ADDR == tox_pkg::ADDR_ERROR_INSERT);
  assign wr_man = I_REG_WR & (I_REG_ADDR == tox_pkg::ADDR_MANUAL);
  assign set = wr_err ? (I_REG_WDATA & tox_pkg::ERR_PEND_MASK) : 8'h00;

  // Receive CRC error pulses arrive from the receive timing, edge taken after sync
  assign crc_evt = st_q.sync2 & ~st_q.last;

  // Shift drops the frame bit in T1 or bit 1 of slot 0 in E1
  assign shift_drop = I_BIT_EN & st_q.err[tox_pkg::ERR_SHIFT] &
    ((I_LINE_RATE_T1 & I_POS_FBIT) |
     (e1 & ~st_q.err[tox_pkg::ERR_DIR] & I_POS_TS0_BIT1));
  // Insert case emits an extra one and holds the upstream bit
  assign shift_ins = I_BIT_EN & st_q.err[tox_pkg::ERR_SHIFT] & e1 &
    st_q.err[tox_pkg::ERR_DIR] & I_POS_FAS_FIRST;
  assign O_STALL = shift_ins;

  // Manual spare byte selection, one enable per spare byte
  genvar g;
  generate
    for (g = 0; g < SPARE_BYTES; g++)
    begin : g_spare
      assign spare_hit[g] = I_POS_SPARE[g] & st_q.man[tox_pkg::MAN_SPARE_LO + g];
    end
  endgenerate

  // Bit overlay, error injection and register updates
  always_comb
  begin
    st_d = st_q;
    clr = 8'h00;
    b = I_SYS_DATA;
    if (I_PRBS_ACTIVE)
      b = I_PRBS_BIT;
    if (I_POS_FBIT & st_q.fmt[tox_pkg::FMT_FBIT])
      b = I_GEN_FBIT;
    if (I_POS_MF & st_q.fmt[tox_pkg::FMT_MF])
      b = I_GEN_MF;
    if (I_POS_CRC & st_q.fmt[tox_pkg::FMT_CRC])
      b = I_GEN_CRC;
    if (I_POS_YEL & st_q.fmt[tox_pkg::FMT_YEL])
      b = I_GEN_YEL;
    // Multiframe yellow has no meaning on a T1 line, so it is gated off there
    if (I_POS_MYEL & st_q.fmt[tox_pkg::FMT_MYEL] & e1)
      b = I_GEN_MYEL;
    if (|spare_hit)
      b = I_GEN_SPARE;
    // Far-end bits: automatic is active low, manual wins when selected
    if (e1 & st_q.fmt[tox_pkg::FMT_FE] & I_POS_FEBE13)
      b = st_q.man[tox_pkg::MAN_OVR] ? st_q.man[tox_pkg::MAN_FEBE13] : ~st_q.use_err[0];
    if (e1 & st_q.fmt[tox_pkg::FMT_FE] & I_POS_FEBE15)
      b = st_q.man[tox_pkg::MAN_OVR] ? st_q.man[tox_pkg::MAN_FEBE15] : ~st_q.use_err[1];
    if (I_BIT_EN)
    begin
      // Each request except shift inverts one bit and then drops
      if (I_POS_FBIT & st_q.err[tox_pkg::ERR_FBIT])
      begin
        b = ~b;
        clr[tox_pkg::ERR_FBIT] = 1'b1;
      end
      if (I_POS_MF & st_q.err[tox_pkg::ERR_MF])
      begin
        b = ~b;
        clr[tox_pkg::ERR_MF] = 1'b1;
      end
      if (I_POS_CRC & st_q.err[tox_pkg::ERR_CRC])
      begin
        b = ~b;
        clr[tox_pkg::ERR_CRC] = 1'b1;
      end
      if (I_POS_MAS_FIRST & st_q.err[tox_pkg::ERR_MAS])
      begin
        b = ~b;
        clr[tox_pkg::ERR_MAS] = 1'b1;
      end
      if (I_PRBS_ACTIVE & st_q.err[tox_pkg::ERR_PAT])
      begin
        b = ~b;
        clr[tox_pkg::ERR_PAT] = 1'b1;
      end
      if (shift_drop | shift_ins)
        clr[tox_pkg::ERR_SHIFT] = 1'b1;
      if (shift_ins)
        b = 1'b1;
    end
    clr[tox_pkg::ERR_LCV] = lif.lcv_done;
    // A write in the same cycle as a clear keeps the request
    st_d.err = (st_q.err & ~clr) | set;
    if (wr_err)
      st_d.err[tox_pkg::ERR_DIR] = I_REG_WDATA[tox_pkg::ERR_DIR];
    if (wr_fmt)
      st_d.fmt = I_REG_WDATA & tox_pkg::FMT_MASK;
    if (wr_man)
      st_d.man = I_REG_WDATA;
    st_d.tx_data = I_BIT_EN ? b : st_q.tx_data;
    st_d.tx_valid = I_BIT_EN & ~shift_drop;
    st_d.slip_adj = shift_drop | shift_ins;
    st_d.slip_ins = (shift_drop | shift_ins) ? shift_ins : st_q.slip_ins;
    // Receive error hold for a whole multiframe, new events win over the handoff
    st_d.sync1 = {I_RX_CRC_ERR_SMF2, I_RX_CRC_ERR_SMF1};
    st_d.sync2 = st_q.sync1;
    st_d.last = st_q.sync2;
    st_d.hold = crc_evt | (st_q.hold & ~{2{I_MF_START}});
    if (I_MF_START)
      st_d.use_err = st_q.hold;
    case (I_REG_ADDR)
      tox_pkg::ADDR_FRAME_FORMAT: st_d.rdata = st_q.fmt;
      tox_pkg::ADDR_ERROR_INSERT: st_d.rdata = st_q.err;
      tox_pkg::ADDR_MANUAL: st_d.rdata = st_q.man;
      default: st_d.rdata = 8'h00;
    endcase
  end

  // State register, synchronous reset
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RESET)
      st_q <= '{fmt: tox_pkg::REG_RESET, err: tox_pkg::REG_RESET,
                man: tox_pkg::REG_RESET, rdata: 8'h00, tx_data: 1'b0,
                tx_valid: 1'b0, slip_adj: 1'b0, slip_ins: 1'b0, sync1: 2'h0,
                sync2: 2'h0, last: 2'h0, hold: 2'h0, use_err: 2'h0};
    else
      st_q <= st_d;
  end

  // Line encoder shares the same final bit as the loopback tap
  assign lif.bit_val = st_q.tx_data;
  assign lif.bit_vld = st_q.tx_valid;
  assign lif.lcv_req = st_q.err[tox_pkg::ERR_LCV];
  assign lif.e1_mode = e1;

  tox_line_encoder u_enc (
    .i_clk (I_CORE_CLK),
    .i_reset (I_RESET),
    .lif (lif)
  );

  // Outputs straight from flip-flops
  assign O_REG_RDATA = st_q.rdata;
  assign O_TX_DATA = st_q.tx_data;
  assign O_TX_VALID = st_q.tx_valid;
  assign O_SLIP_ADJ = st_q.slip_adj;
  assign O_SLIP_ADJ_INSERT = st_q.slip_ins;
  assign O_DIG_POS = lif.pos;
  assign O_DIG_NEG = lif.neg;
  assign O_ANA_POS = lif.pos;
  assign O_ANA_NEG = lif.neg;

  // Checks on insertion and injection
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RESET);

  chk_fbit_insert: assert property (
    (I_BIT_EN & I_POS_FBIT & st_q.fmt[tox_pkg::FMT_FBIT] & ~st_q.err[tox_pkg::ERR_FBIT]
     & ~shift_drop & ~I_POS_CRC & ~I_POS_MF)
    |=> O_TX_VALID && (O_TX_DATA == $past(I_GEN_FBIT)))
    else $error("Frame bit not taken from formatter");
  chk_fbit_bypass: assert property (
    (I_BIT_EN & I_POS_FBIT & ~st_q.fmt[tox_pkg::FMT_FBIT] & ~st_q.err[tox_pkg::ERR_FBIT]
     & ~shift_drop & ~I_PRBS_ACTIVE & ~I_POS_CRC & ~I_POS_MF & ~I_POS_YEL)
    |=> O_TX_DATA == $past(I_SYS_DATA))
    else $error("Bypassed frame bit altered");
  chk_crc_invert: assert property (
    (I_BIT_EN & I_POS_CRC & st_q.fmt[tox_pkg::FMT_CRC] & st_q.err[tox_pkg::ERR_CRC]
     & ~wr_err & ~I_POS_FBIT & ~I_POS_MF & ~I_POS_YEL & ~I_POS_MYEL & ~(|spare_hit)
     & ~I_POS_MAS_FIRST & ~(I_PRBS_ACTIVE & st_q.err[tox_pkg::ERR_PAT]))
    |=> (O_TX_DATA != $past(I_GEN_CRC)) && !st_q.err[tox_pkg::ERR_CRC])
    else $error("CRC error not injected once");
  chk_prbs_invert: assert property (
    (I_BIT_EN & I_PRBS_ACTIVE & st_q.err[tox_pkg::ERR_PAT] & ~I_POS_FBIT & ~I_POS_MF
     & ~I_POS_CRC & ~I_POS_MAS_FIRST & ~I_POS_YEL & ~I_POS_MYEL & ~(|spare_hit)
     & ~I_POS_FEBE13 & ~I_POS_FEBE15 & ~shift_ins)
    |=> O_TX_DATA != $past(I_PRBS_BIT))
    else $error("Pattern bit not inverted");
  chk_febe_manual: assert property (
    (I_BIT_EN & e1 & I_POS_FEBE13 & st_q.fmt[tox_pkg::FMT_FE] & st_q.man[tox_pkg::MAN_OVR]
     & ~I_POS_FBIT & ~I_POS_MF & ~I_POS_CRC & ~I_PRBS_ACTIVE & ~shift_drop)
    |=> O_TX_DATA == $past(st_q.man[tox_pkg::MAN_FEBE13]))
    else $error("Manual frame 13 bit not sent");
  chk_febe_hold: assert property (
    (crc_evt[0] ##1 I_MF_START) |=> st_q.use_err[0])
    else $error("Receive CRC error not carried into multiframe");
  chk_shift_drop: assert property (
    shift_drop |=> !O_TX_VALID && O_SLIP_ADJ && !O_SLIP_ADJ_INSERT)
    else $error("Shift did not drop the bit");
  chk_shift_insert: assert property (
    shift_ins |-> O_STALL ##1 (O_TX_DATA && O_TX_VALID && O_SLIP_ADJ_INSERT))
    else $error("Shift did not insert a one");
  chk_w1s_request: assert property (
    (wr_err & I_REG_WDATA[tox_pkg::ERR_FBIT]) |=> st_q.err[tox_pkg::ERR_FBIT])
    else $error("Error request not latched");
  chk_lcv_latched: assert property (
    (st_q.err[tox_pkg::ERR_LCV] & ~lif.lcv_done) |=> st_q.err[tox_pkg::ERR_LCV])
    else $error("Violation request lost before use");

  cov_shift_ins: cover property (shift_ins ##1 O_SLIP_ADJ);
  cov_lcv_done: cover property (st_q.err[tox_pkg::ERR_LCV] ##[1:400] lif.lcv_done);
  cov_febe_auto: cover property (I_MF_START & st_q.hold[1]);
endmodule

`default_nettype wire

// ---- verification/tox_far_end.sv ----
/*
  Far end terminal model: watches the bipolar line rails and counts violations.
  Assumes one-cycle mark pulses on the core clock, first mark positive.
*/
`timescale 1ns/10ps
`default_nettype none

module tox_far_end (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_pos,
  input wire logic i_neg,
  output logic [7:0] o_bpv_cnt
);
  logic last_pos_q;

  // Mark with the same polarity as the one before is a violation
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      last_pos_q <= 1'b0;
      o_bpv_cnt <= 8'h00;
    end
    else if (i_pos || i_neg)
    begin
      last_pos_q <= i_pos;
      if (i_pos == last_pos_q)
        o_bpv_cnt <= o_bpv_cnt + 8'h01;
    end
  end
endmodule

`default_nettype wire

// ---- verification/tox_overhead_bench.sv ----
/*
  Self-checking bench for the overhead insert and error inject block.
  Assumes the register port and bit slot timing of the hand-over contract.
*/
`timescale 1ns/10ps
`default_nettype none

module tox_overhead_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic t1 = 1'b0;
  logic ben = 1'b0;
  logic sys = 1'b0;
  logic [9:0] pos_v = 10'h000;
  logic [4:0] sp = 5'h00;
  logic mfs = 1'b0;
  logic gen = 1'b0;
  logic pra = 1'b0;
  logic rx1 = 1'b0;
  logic rx2 = 1'b0;
  logic [7:0] rdata;
  logic txd, txv, stall, adj, adji, dp, dn, ap, an;
  logic [7:0] bpv;
  logic [7:0] bpv_d;
  logic [7:0] base_d;
  logic txd_s, txv_s, adj_s, stall_s;
  logic [7:0] eb [5] = '{8'h80, 8'h40, 8'h20, 8'h04, 8'h02};
  logic [9:0] ep [5] = '{10'h020, 10'h002, 10'h000, 10'h004, 10'h001};
  logic epr [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  logic [7:0] base;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;

  tox_overhead dut_u (.I_CORE_CLK(clk), .I_RESET(rst), .I_REG_ADDR(addr),
    .I_REG_WDATA(wdata), .I_REG_WR(wr), .O_REG_RDATA(rdata), .I_LINE_RATE_T1(t1),
    .I_BIT_EN(ben), .I_SYS_DATA(sys), .I_POS_FBIT(pos_v[0]), .I_POS_MF(pos_v[1]),
    .I_POS_CRC(pos_v[2]), .I_POS_YEL(pos_v[3]), .I_POS_MYEL(pos_v[4]),
    .I_POS_MAS_FIRST(pos_v[5]), .I_POS_TS0_BIT1(pos_v[6]), .I_POS_FAS_FIRST(pos_v[7]),
    .I_POS_FEBE13(pos_v[8]), .I_POS_FEBE15(pos_v[9]), .I_POS_SPARE(sp),
    .I_MF_START(mfs), .I_GEN_FBIT(gen), .I_GEN_MF(gen), .I_GEN_CRC(gen),
    .I_GEN_YEL(gen), .I_GEN_MYEL(gen), .I_GEN_SPARE(gen), .I_PRBS_ACTIVE(pra),
    .I_PRBS_BIT(gen), .I_RX_CRC_ERR_SMF1(rx1), .I_RX_CRC_ERR_SMF2(rx2),
    .O_TX_DATA(txd), .O_TX_VALID(txv), .O_STALL(stall), .O_SLIP_ADJ(adj),
    .O_SLIP_ADJ_INSERT(adji), .O_DIG_POS(dp), .O_DIG_NEG(dn), .O_ANA_POS(ap),
    .O_ANA_NEG(an));

  tox_far_end far_u (.i_clk(clk), .i_reset(rst), .i_pos(ap), .i_neg(an),
    .o_bpv_cnt(bpv));
  // Second terminal on the digital rails, both outputs must carry the error
  tox_far_end far_d_u (.i_clk(clk), .i_reset(rst), .i_pos(dp), .i_neg(dn),
    .o_bpv_cnt(bpv_d));

  // Core clock, 50 ns period
  initial
  begin
    forever #25 clk = ~clk;
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data is registered, so look one edge after the address lands
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    #1 cmp("rdata", exp, rdata);
  endtask

  // One line bit slot; stall is combinational, outputs one edge later
  task automatic slot(input logic [9:0] p, input logic [4:0] s5, input logic pr,
                      input logic sd, input logic g);
    @(posedge clk);
    pos_v <= p;
    sp <= s5;
    pra <= pr;
    sys <= sd;
    gen <= g;
    ben <= 1'b1;
    #1 stall_s = stall;
    @(posedge clk);
    ben <= 1'b0;
    pos_v <= 10'h000;
    sp <= 5'h00;
    pra <= 1'b0;
    #1 txd_s = txd;
    txv_s = txv;
    adj_s = adj;
  endtask

  task automatic mf_pulse();
    @(posedge clk);
    mfs <= 1'b1;
    @(posedge clk);
    mfs <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic finish_test();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int a = 8'h72; a <= 8'h75; a++)
      rd_chk(8'(a), 8'h00);
    wr_reg(8'h72, 8'hFF);
    rd_chk(8'h72, 8'h3F);
    wr_reg(8'h75, 8'hFF);
    rd_chk(8'h75, 8'h00);
    // Enables off pass system data, on take the formatter value
    for (int en = 0; en < 2; en++)
    begin
      wr_reg(8'h72, en ? 8'h3F : 8'h00);
      for (int i = 0; i < 5; i++)
      begin
        slot(10'h001 << i, 5'h00, 1'b0, 1'b0, 1'b1);
        cmp("overhead", 8'(en), txd_s);
      end
    end
    // Each one-shot waits for its own slot kind, then clears
    for (int i = 0; i < 5; i++)
    begin
      wr_reg(8'h73, eb[i]);
      slot(10'h000, 5'h00, 1'b0, 1'b0, 1'b0);
      cmp("plain", 8'h00, txd_s);
      slot(ep[i], 5'h00, epr[i], 1'b0, 1'b0);
      cmp("inject", 8'h01, txd_s);
      rd_chk(8'h73, 8'h00);
      slot(ep[i], 5'h00, epr[i], 1'b0, 1'b0);
      cmp("again", 8'h00, txd_s);
    end
    t1 <= 1'b1;
    wr_reg(8'h73, 8'h08);
    slot(10'h001, 5'h00, 1'b0, 1'b0, 1'b0);
    cmp("t1_valid", 8'h00, txv_s);
    cmp("t1_adj", 8'h01, adj_s);
    t1 <= 1'b0;
    wr_reg(8'h73, 8'h08);
    slot(10'h040, 5'h00, 1'b0, 1'b0, 1'b0);
    cmp("del_valid", 8'h00, txv_s);
    cmp("del_kind", 8'h00, adji);
    wr_reg(8'h73, 8'h18);
    slot(10'h080, 5'h00, 1'b0, 1'b0, 1'b0);
    cmp("ins_stall", 8'h01, stall_s);
    cmp("ins_data", 8'h01, txd_s);
    cmp("ins_kind", 8'h01, adji);
    rd_chk(8'h73, 8'h10);
    wr_reg(8'h73, 8'h00);
    // Far-end bits: manual, automatic, then bypass
    wr_reg(8'h72, 8'h04);
    wr_reg(8'h74, 8'h07);
    rd_chk(8'h74, 8'h07);
    slot(10'h140, 5'h00, 1'b0, 1'b0, 1'b0);
    cmp("man13", 8'h01, txd_s);
    slot(10'h240, 5'h00, 1'b0, 1'b0, 1'b0);
    cmp("man15", 8'h01, txd_s);
    wr_reg(8'h74, 8'h01);
    slot(10'h140, 5'h00, 1'b0, 1'b1, 1'b0);
    cmp("man13", 8'h00, txd_s);
    wr_reg(8'h74, 8'h00);
    slot(10'h140, 5'h00, 1'b0, 1'b0, 1'b0);
    cmp("auto13", 8'h01, txd_s);
    @(posedge clk);
    rx1 <= 1'b1;
    repeat (3) @(posedge clk);
    rx1 <= 1'b0;
    repeat (4) @(posedge clk);
    mf_pulse();
    slot(10'h140, 5'h00, 1'b0, 1'b1, 1'b0);
    cmp("auto13", 8'h00, txd_s);
    slot(10'h240, 5'h00, 1'b0, 1'b0, 1'b0);
    cmp("auto15", 8'h01, txd_s);
    mf_pulse();
    slot(10'h140, 5'h00, 1'b0, 1'b0, 1'b0);
    cmp("auto13", 8'h01, txd_s);
    wr_reg(8'h72, 8'h00);
    slot(10'h140, 5'h00, 1'b0, 1'b1, 1'b0);
    cmp("bypass13", 8'h01, txd_s);
    // Spare byte enable picks the manual value only for its own byte
    wr_reg(8'h74, 8'h08);
    slot(10'h000, 5'h01, 1'b0, 1'b0, 1'b1);
    cmp("spare4", 8'h01, txd_s);
    slot(10'h000, 5'h02, 1'b0, 1'b0, 1'b1);
    cmp("spare5", 8'h00, txd_s);
    // Violation: one same-polarity mark in T1, two in E1
    for (int k = 1; k >= 0; k--)
    begin
      t1 <= k[0];
      base = bpv;
      base_d = bpv_d;
      wr_reg(8'h73, 8'h01);
      repeat (6) slot(10'h000, 5'h00, 1'b0, 1'b1, 1'b0);
      repeat (4) @(posedge clk);
      cmp("bpv", base + (k ? 8'h01 : 8'h02), bpv);
      cmp("bpv_dig", base_d + (k ? 8'h01 : 8'h02), bpv_d);
      rd_chk(8'h73, 8'h00);
    end
    finish_test();
  end
endmodule

`default_nettype wire
